// ==== hw/cisr_pkg.sv ====
package cisr_pkg;

  localparam logic [7:0] CISR_OFF_INT_STATUS_MASK = 8'h0c;
  localparam logic [7:0] CISR_OFF_SOFT_RESET      = 8'h0d;
  localparam logic [7:0] CISR_OFF_GENERIC_DECODE  = 8'h0e;
  localparam logic [7:0] CISR_OFF_PAGE_SELECT     = 8'h0f;
  localparam logic [7:0] CISR_OFF_PIN_CONFIG      = 8'h09;
  localparam logic [7:0] CISR_OFF_DIVIDER         = 8'h0a;
  localparam logic [7:0] CISR_OFF_CONFIG_OPTIONS  = 8'hf8;
  localparam logic [7:0] CISR_OFF_CONFIG_STATUS   = 8'hfa;

  localparam int CISR_BIT_UART_INT   = 4;
  localparam int CISR_BIT_MASK_PIN1  = 3;
  localparam int CISR_BIT_MASK_PIN0  = 2;
  localparam int CISR_BIT_STATE_PIN1 = 1;
  localparam int CISR_BIT_STATE_PIN0 = 0;
  localparam int CISR_BIT_UART_RST   = 1;
  localparam int CISR_BIT_BUS_RST    = 0;
  localparam int CISR_BIT_GENERIC_EN = 0;
  localparam int CISR_BIT_PAGE       = 0;
  localparam int CISR_BIT_CARD_RST   = 7;
  localparam int CISR_BIT_LEVEL_IRQ  = 6;
  localparam int CISR_BIT_INTR       = 1;
  localparam int CISR_GEN_ADDR_BITS  = 3;

  localparam logic [2:0] CISR_RST_PULSE_DIV  = 3'h5;
  localparam logic [2:0] CISR_RST_UART_DIV   = 3'h0;
  localparam logic [3:0] CISR_RST_PIN_CONFIG = 4'h0;
  localparam logic [1:0] CISR_RST_MASK       = 2'h0;
  localparam logic [1:0] CISR_RST_SOFT       = 2'h0;
  localparam logic [7:0] CISR_RST_OPTIONS    = 8'h00;
  localparam logic       CISR_RST_PAGE       = 1'b0;

  // Pulse divider counts clk cycles; one divided period is 2^code cycles.
  localparam int CISR_DIV_CNT_W = 8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cisr_host_req_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cisr_eeprom_req_t;

  typedef enum logic [1:0] {
    CISR_IRQ_IDLE  = 2'b00,
    CISR_IRQ_WAIT  = 2'b01,
    CISR_IRQ_PULSE = 2'b10,
    CISR_IRQ_HOLD  = 2'b11
  } cisr_irq_state_t;

endpackage : cisr_pkg

// ==== hw/cisr_card_irq.sv ====
`timescale 1ns/10ps
`default_nettype none
module cisr_card_irq
  import cisr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire cisr_host_req_t   host_req,
  output logic [7:0]            host_rdata,
  input  wire cisr_eeprom_req_t ee_req,
  input  wire logic             uart_irq,
  input  wire logic [1:0]       multipurpose_pin,
  input  wire logic             mode_pin,
  output logic                  uart_rst,
  output logic                  local_bus_rst,
  output logic                  card_rst,
  output logic                  generic_mode,
  output logic                  config_overlay,
  output logic [7:0]            uart_addr_mask,
  output logic                  irq_n
);

  logic [1:0]      pin_s1;
  logic [1:0]      pin_s2;
  logic            mode_s1;
  logic            mode_s2;
  logic            uart_s1;
  logic            uart_s2;
  logic [1:0]      int_mask;
  logic [1:0]      next_int_mask;
  logic [1:0]      soft_rst;
  logic [1:0]      next_soft_rst;
  logic            generic_en;
  logic            next_generic_en;
  logic            overlay;
  logic            next_overlay;
  logic [3:0]      pin_config;
  logic [3:0]      next_pin_config;
  logic [2:0]      uart_div;
  logic [2:0]      next_uart_div;
  logic [2:0]      pulse_div;
  logic [2:0]      next_pulse_div;
  logic [7:0]      options;
  logic [7:0]      next_options;
  logic [1:0]      pin_state;
  logic            irq_any;
  logic            level_mode;
  logic [CISR_DIV_CNT_W-1:0] div_cnt;
  logic [CISR_DIV_CNT_W-1:0] next_div_cnt;
  logic            div_tick;
  cisr_irq_state_t irq_state;
  cisr_irq_state_t next_irq_state;
  logic            pulse_out;
  logic            next_pulse_out;
  logic [7:0]      next_rdata;

  function automatic logic host_wr_to(input cisr_host_req_t r, input logic [7:0] off);
    host_wr_to = r.wr && (r.addr == off);
  endfunction : host_wr_to

  function automatic logic ee_wr_to(input cisr_eeprom_req_t r, input logic [7:0] off);
    ee_wr_to = r.wr && (r.addr == off);
  endfunction : ee_wr_to

  // Low prescaler bits that must all be set for one divided clock edge.
  function automatic logic [CISR_DIV_CNT_W-1:0] div_mask(input logic [2:0] code);
    div_mask = (8'h01 << code) - 8'h01;
  endfunction : div_mask

  // Only the two input configurations carry a polarity; an output code keeps the raw level.
  function automatic logic pin_polarity(input logic [1:0] cfg, input logic lvl);
    pin_polarity = (cfg == 2'h1) ? ~lvl : lvl;
  endfunction : pin_polarity

  // Pins, mode strap and the asynchronous UART interrupt all come from outside this domain.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1  <= 2'h0;
      pin_s2  <= 2'h0;
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      uart_s1 <= 1'b0;
      uart_s2 <= 1'b0;
    end else begin
      pin_s1  <= multipurpose_pin;
      pin_s2  <= pin_s1;
      mode_s1 <= mode_pin;
      mode_s2 <= mode_s1;
      uart_s1 <= uart_irq;
      uart_s2 <= uart_s1;
    end
  end

  assign pin_state[1] = pin_polarity(pin_config[3:2], pin_s2[1]);
  assign pin_state[0] = pin_polarity(pin_config[1:0], pin_s2[0]);

  // Three sources only, each pin gated by its own mask bit.
  assign irq_any = uart_s2
                 | (pin_state[1] & int_mask[1])
                 | (pin_state[0] & int_mask[0]);

  assign level_mode = options[CISR_BIT_LEVEL_IRQ];

  always_comb begin
    next_int_mask   = int_mask;
    next_soft_rst   = soft_rst;
    next_generic_en = generic_en;
    next_overlay    = overlay;
    next_pin_config = pin_config;
    next_uart_div   = uart_div;
    next_pulse_div  = pulse_div;
    next_options    = options;
    // EEPROM loads first so that a simultaneous host write takes precedence.
    if (ee_wr_to(ee_req, CISR_OFF_INT_STATUS_MASK)) begin
      next_int_mask = ee_req.wdata[CISR_BIT_MASK_PIN1:CISR_BIT_MASK_PIN0];
    end
    if (ee_wr_to(ee_req, CISR_OFF_SOFT_RESET)) begin
      next_soft_rst = ee_req.wdata[CISR_BIT_UART_RST:CISR_BIT_BUS_RST];
    end
    if (ee_wr_to(ee_req, CISR_OFF_GENERIC_DECODE)) begin
      next_generic_en = ee_req.wdata[CISR_BIT_GENERIC_EN];
    end
    if (ee_wr_to(ee_req, CISR_OFF_PIN_CONFIG)) begin
      next_pin_config = ee_req.wdata[3:0];
    end
    if (ee_wr_to(ee_req, CISR_OFF_DIVIDER)) begin
      next_uart_div  = ee_req.wdata[5:3];
      next_pulse_div = ee_req.wdata[2:0];
    end
    if (host_wr_to(host_req, CISR_OFF_INT_STATUS_MASK)) begin
      next_int_mask = host_req.wdata[CISR_BIT_MASK_PIN1:CISR_BIT_MASK_PIN0];
    end
    if (host_wr_to(host_req, CISR_OFF_SOFT_RESET)) begin
      next_soft_rst = host_req.wdata[CISR_BIT_UART_RST:CISR_BIT_BUS_RST];
    end
    if (host_wr_to(host_req, CISR_OFF_PIN_CONFIG)) begin
      next_pin_config = host_req.wdata[3:0];
    end
    if (host_wr_to(host_req, CISR_OFF_DIVIDER)) begin
      next_uart_div  = host_req.wdata[5:3];
      next_pulse_div = host_req.wdata[2:0];
    end
    if (host_wr_to(host_req, CISR_OFF_CONFIG_OPTIONS)) begin
      next_options = host_req.wdata;
    end
    // While generic decode is on, writing 1 to the page bit enters the overlay; writing 0 leaves it.
    if (generic_en && host_wr_to(host_req, CISR_OFF_PAGE_SELECT)) begin
      next_overlay = host_req.wdata[CISR_BIT_PAGE];
    end
    if (!generic_en) begin
      next_overlay = CISR_RST_PAGE;
    end
  end

  // The card-wide soft reset clears local state except the options register, whose bits it never clears.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_mask   <= CISR_RST_MASK;
      soft_rst   <= CISR_RST_SOFT;
      generic_en <= 1'b0;
      overlay    <= CISR_RST_PAGE;
      pin_config <= CISR_RST_PIN_CONFIG;
      uart_div   <= CISR_RST_UART_DIV;
      pulse_div  <= CISR_RST_PULSE_DIV;
      options    <= CISR_RST_OPTIONS;
    end else if (options[CISR_BIT_CARD_RST]) begin
      int_mask   <= CISR_RST_MASK;
      soft_rst   <= CISR_RST_SOFT;
      generic_en <= 1'b0;
      overlay    <= CISR_RST_PAGE;
      pin_config <= CISR_RST_PIN_CONFIG;
      uart_div   <= CISR_RST_UART_DIV;
      pulse_div  <= CISR_RST_PULSE_DIV;
      options    <= next_options & {1'b1, 7'h7f};
    end else begin
      int_mask   <= next_int_mask;
      soft_rst   <= next_soft_rst;
      generic_en <= next_generic_en;
      overlay    <= next_overlay;
      pin_config <= next_pin_config;
      uart_div   <= next_uart_div;
      pulse_div  <= next_pulse_div;
      options    <= next_options;
    end
  end

  // Prescaler for the pulse width: a tick every 2^code clk cycles, so code 0 ticks every cycle.
  always_comb begin
    next_div_cnt = div_cnt + 8'h01;
    div_tick     = (div_cnt & div_mask(pulse_div)) == div_mask(pulse_div);
    if (div_tick) begin
      next_div_cnt = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Pulse request: wait for a divided clock boundary, pulse for one divided period,
  // then hold until all sources go quiet so one request gives one pulse.
  always_comb begin
    next_irq_state = irq_state;
    next_pulse_out = pulse_out;
    unique case (irq_state)
      CISR_IRQ_IDLE: begin
        if (irq_any && !level_mode) begin
          next_irq_state = CISR_IRQ_WAIT;
        end
      end
      CISR_IRQ_WAIT: begin
        if (div_tick) begin
          next_irq_state = CISR_IRQ_PULSE;
          next_pulse_out = 1'b1;
        end
      end
      CISR_IRQ_PULSE: begin
        if (div_tick) begin
          next_irq_state = CISR_IRQ_HOLD;
          next_pulse_out = 1'b0;
        end
      end
      CISR_IRQ_HOLD: begin
        if (!irq_any) begin
          next_irq_state = CISR_IRQ_IDLE;
        end
      end
    endcase
    if (level_mode) begin
      next_irq_state = CISR_IRQ_IDLE;
      next_pulse_out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_state <= CISR_IRQ_IDLE;
      pulse_out <= 1'b0;
    end else begin
      irq_state <= next_irq_state;
      pulse_out <= next_pulse_out;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (host_req.rd) begin
      unique case (host_req.addr)
        CISR_OFF_INT_STATUS_MASK: begin
          next_rdata[CISR_BIT_UART_INT]   = uart_s2;
          next_rdata[CISR_BIT_MASK_PIN1]  = int_mask[1];
          next_rdata[CISR_BIT_MASK_PIN0]  = int_mask[0];
          next_rdata[CISR_BIT_STATE_PIN1] = pin_state[1];
          next_rdata[CISR_BIT_STATE_PIN0] = pin_state[0];
        end
        CISR_OFF_SOFT_RESET:     next_rdata[1:0] = soft_rst;
        CISR_OFF_GENERIC_DECODE: next_rdata[CISR_BIT_GENERIC_EN] = generic_en;
        CISR_OFF_PIN_CONFIG:     next_rdata[3:0] = pin_config;
        CISR_OFF_DIVIDER:        next_rdata[5:0] = {uart_div, pulse_div};
        CISR_OFF_CONFIG_OPTIONS: next_rdata = options;
        CISR_OFF_CONFIG_STATUS:  next_rdata[CISR_BIT_INTR] = irq_any;
        default:                 next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= 8'h00;
    end else begin
      host_rdata <= next_rdata;
    end
  end

  assign uart_rst       = soft_rst[CISR_BIT_UART_RST] | options[CISR_BIT_CARD_RST];
  assign local_bus_rst  = (soft_rst[CISR_BIT_BUS_RST] & mode_s2)
                        | options[CISR_BIT_CARD_RST];
  assign card_rst       = options[CISR_BIT_CARD_RST];
  assign generic_mode   = generic_en;
  assign config_overlay = overlay;
  assign uart_addr_mask = generic_en ? 8'h07 : 8'hff;
  assign irq_n          = level_mode ? ~irq_any : ~pulse_out;

endmodule : cisr_card_irq
`default_nettype wire

// ==== dv/cisr_card_irq_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module cisr_card_irq_properties
  import cisr_pkg::*;
(
  input wire logic             clk,
  input wire logic             rstn,
  input wire cisr_host_req_t   host_req,
  input wire logic [7:0]       host_rdata,
  input wire cisr_eeprom_req_t ee_req,
  input wire logic             uart_irq,
  input wire logic [1:0]       multipurpose_pin,
  input wire logic             mode_pin,
  input wire logic             uart_rst,
  input wire logic             local_bus_rst,
  input wire logic             card_rst,
  input wire logic             generic_mode,
  input wire logic             config_overlay,
  input wire logic [7:0]       uart_addr_mask,
  input wire logic             irq_n
);
  logic lvl;
  logic next_lvl;
  logic wr_soft;
  logic [2:0] pdiv;
  logic [2:0] next_pdiv;
  logic [8:0] low_run;
  logic [8:0] next_low;

  // The level select bit is shadowed here because the design keeps it internal.
  always_comb begin
    next_lvl = lvl;
    if (host_req.wr && host_req.addr == CISR_OFF_CONFIG_OPTIONS)
      next_lvl = host_req.wdata[CISR_BIT_LEVEL_IRQ];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      lvl <= 1'b0;
    else
      lvl <= next_lvl;
  end

  // Shadow of the pulse divide code and the length of the current low run of the request.
  always_comb begin
    next_pdiv = pdiv;
    if (ee_req.wr && ee_req.addr == CISR_OFF_DIVIDER)
      next_pdiv = ee_req.wdata[2:0];
    if (host_req.wr && host_req.addr == CISR_OFF_DIVIDER)
      next_pdiv = host_req.wdata[2:0];
    if (card_rst)
      next_pdiv = CISR_RST_PULSE_DIV;
    next_low = 9'h000;
    if (!irq_n && !lvl)
      next_low = low_run + 9'h001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pdiv    <= CISR_RST_PULSE_DIV;
      low_run <= 9'h000;
    end else begin
      pdiv    <= next_pdiv;
      low_run <= next_low;
    end
  end

  assign wr_soft = (host_req.wr && host_req.addr == CISR_OFF_SOFT_RESET)
                 || (ee_req.wr && ee_req.addr == CISR_OFF_SOFT_RESET);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_card_rst_both: assert property (card_rst |-> uart_rst && local_bus_rst)
    else $error("card reset not passed on");
  a_bus_rst_mode: assert property ((!mode_pin && !card_rst) [*8] |-> !local_bus_rst)
    else $error("bus reset in normal mode");
  a_addr_mask_sel: assert property (uart_addr_mask == (generic_mode ? 8'h07 : 8'hff))
    else $error("address mask wrong");
  a_level_irq_low: assert property (lvl && $past(lvl) && !card_rst && $past(uart_irq, 2)
    && $past(uart_irq, 3) && $past(uart_irq, 4) |-> !irq_n)
    else $error("level request missing");
  a_pulse_width: assert property (!lvl && !$past(lvl) && $rose(irq_n)
    |-> low_run == (9'h001 << pdiv))
    else $error("pulse width wrong");
  a_resv_zero: assert property ($past(host_req.rd)
    && $past(host_req.addr) == CISR_OFF_SOFT_RESET |-> host_rdata[7:2] == 6'h00)
    else $error("reserved bits not zero");
  a_uart_status: assert property ($past(host_req.rd)
    && $past(host_req.addr) == CISR_OFF_INT_STATUS_MASK
    && $past(uart_irq, 2) == $past(uart_irq, 3) && $past(uart_irq, 3) == $past(uart_irq, 4)
    |-> host_rdata[4] == $past(uart_irq, 3))
    else $error("uart status bit wrong");
  a_soft_rst_hold: assert property ($fell(uart_rst) && !$past(card_rst)
    && !$past(card_rst, 2) |-> $past(wr_soft) || $past(wr_soft, 2))
    else $error("uart reset cleared itself");
  a_overlay_gen: assert property ($rose(config_overlay) |-> generic_mode)
    else $error("overlay outside generic mode");
endmodule : cisr_card_irq_properties

bind cisr_card_irq cisr_card_irq_properties u_props (.clk(clk), .rstn(rstn),
  .host_req(host_req), .host_rdata(host_rdata), .ee_req(ee_req), .uart_irq(uart_irq),
  .multipurpose_pin(multipurpose_pin), .mode_pin(mode_pin), .uart_rst(uart_rst),
  .local_bus_rst(local_bus_rst), .card_rst(card_rst), .generic_mode(generic_mode),
  .config_overlay(config_overlay), .uart_addr_mask(uart_addr_mask), .irq_n(irq_n));
`default_nettype wire

// ==== dv/cisr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cisr_host_model
  import cisr_pkg::*;
(
  input  wire logic     clk,
  output cisr_host_req_t host_req
);
  initial host_req = '0;

  // Idle address and data show the inverse of the last access so stale values never match.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
endmodule : cisr_host_model
`default_nettype wire

// ==== dv/cisr_card_irq_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module cisr_card_irq_test
  import cisr_pkg::*;
;
  logic             clk;
  logic             rstn;
  cisr_host_req_t   host_req;
  logic [7:0]       host_rdata;
  cisr_eeprom_req_t ee_req;
  logic             uart_irq;
  logic [1:0]       multipurpose_pin;
  logic             mode_pin;
  logic             uart_rst;
  logic             local_bus_rst;
  logic             card_rst;
  logic             generic_mode;
  logic             config_overlay;
  logic [7:0]       uart_addr_mask;
  logic             irq_n;
  logic [7:0]       expq[$];
  logic             rd_d = 1'b0;
  logic [31:0]      seed = 32'h6f205e74;
  int               n_errors = 0;
  int               checks = 0;
  int               cnt;

  cisr_host_model u_host (.clk(clk), .host_req(host_req));
  cisr_card_irq u_dut (.clk(clk), .rstn(rstn), .host_req(host_req), .host_rdata(host_rdata),
    .ee_req(ee_req), .uart_irq(uart_irq), .multipurpose_pin(multipurpose_pin),
    .mode_pin(mode_pin), .uart_rst(uart_rst), .local_bus_rst(local_bus_rst),
    .card_rst(card_rst), .generic_mode(generic_mode), .config_overlay(config_overlay),
    .uart_addr_mask(uart_addr_mask), .irq_n(irq_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_host.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Read data stands one cycle after the strobe, so the note is taken then.
  always @(posedge clk) begin
    if (rd_d) begin
      chk(host_rdata, expq.pop_front());
    end
    rd_d <= host_req.rd;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report;
  end

  initial begin
    rstn = 1'b0;
    ee_req = '0;
    uart_irq = 1'b0;
    multipurpose_pin = 2'h0;
    mode_pin = 1'b1;
    cyc(5);
    rstn = 1'b1;
    chk(irq_n, 1'b1);
    chk(uart_addr_mask, 8'hff);
    rd(CISR_OFF_INT_STATUS_MASK, 8'h00);
    rd(CISR_OFF_GENERIC_DECODE, 8'h00);
    rd(CISR_OFF_DIVIDER, 8'h05);
    rd(8'h20, 8'h00);
    repeat (4) begin
      seed = xs(seed);
      wr(CISR_OFF_SOFT_RESET, seed[7:0]);
      rd(CISR_OFF_SOFT_RESET, {6'h00, seed[1:0]});
      chk(uart_rst, seed[1]);
      chk(local_bus_rst, seed[0]);
    end
    wr(CISR_OFF_SOFT_RESET, 8'h03);
    mode_pin = 1'b0;
    cyc(20);
    chk(local_bus_rst, 1'b0);
    chk(uart_rst, 1'b1);
    wr(CISR_OFF_SOFT_RESET, 8'h00);
    chk(uart_rst, 1'b0);
    wr(CISR_OFF_CONFIG_OPTIONS, 8'h80);
    chk(card_rst, 1'b1);
    chk(uart_rst, 1'b1);
    wr(CISR_OFF_CONFIG_OPTIONS, 8'h40);
    uart_irq = 1'b1;
    cyc(4);
    chk(irq_n, 1'b0);
    rd(CISR_OFF_INT_STATUS_MASK, 8'h10);
    rd(CISR_OFF_CONFIG_STATUS, 8'h02);
    uart_irq = 1'b0;
    cyc(4);
    chk(irq_n, 1'b1);
    rd(CISR_OFF_CONFIG_STATUS, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(CISR_OFF_PIN_CONFIG, 8'h01 << (2 * p));
      cyc(4);
      rd(CISR_OFF_INT_STATUS_MASK, 8'h01 << p);
      chk(irq_n, 1'b1);
      wr(CISR_OFF_INT_STATUS_MASK, 8'hff);
      cyc(4);
      chk(irq_n, 1'b0);
      rd(CISR_OFF_INT_STATUS_MASK, 8'h0c | (8'h01 << p));
      multipurpose_pin = 2'h1 << p;
      cyc(4);
      chk(irq_n, 1'b1);
      multipurpose_pin = 2'h0;
      wr(CISR_OFF_INT_STATUS_MASK, 8'h00);
      cyc(4);
      chk(irq_n, 1'b1);
    end
    wr(CISR_OFF_PIN_CONFIG, 8'h00);
    wr(CISR_OFF_CONFIG_OPTIONS, 8'h00);
    for (int c = 0; c < 6; c += 5) begin
      wr(CISR_OFF_DIVIDER, 8'(c));
      uart_irq = 1'b1;
      for (int i = 0; i < 300 && irq_n === 1'b1; i++) cyc(1);
      cnt = 0;
      while (irq_n === 1'b0 && cnt < 300) begin
        cyc(1);
        cnt++;
      end
      chk(8'(cnt), 8'(1 << c));
      cyc(140);
      chk(irq_n, 1'b1);
      uart_irq = 1'b0;
      cyc(4);
    end
    ee_req = '{wr: 1'b1, addr: CISR_OFF_GENERIC_DECODE, wdata: 8'h01};
    cyc(1);
    ee_req = '0;
    chk(generic_mode, 1'b1);
    chk(uart_addr_mask, 8'h07);
    wr(CISR_OFF_PAGE_SELECT, 8'h01);
    chk(config_overlay, 1'b1);
    wr(CISR_OFF_GENERIC_DECODE, 8'h00);
    rd(CISR_OFF_GENERIC_DECODE, 8'h01);
    wr(CISR_OFF_PAGE_SELECT, 8'h00);
    chk(config_overlay, 1'b0);
    cyc(4);
    final_report;
  end
endmodule : cisr_card_irq_test
`default_nettype wire
